// [rtl/wca_pkg.sv]
package wca_pkg;

  // --------------------------------------------------------------------
  // register map
  // --------------------------------------------------------------------
  localparam logic [11:0] ADDR_T1 = 12'hF12; // deny_sample_delay
  localparam logic [11:0] ADDR_T2 = 12'hF13; // direction_switch_delay
  localparam logic [11:0] ADDR_CTRL = 12'hF14;
  localparam logic [11:0] ADDR_CMD = 12'hF15;
  localparam logic [11:0] ADDR_STAT = 12'hF16;

  localparam logic [7:0] T1_RESET = 8'h31;
  localparam logic [7:0] T2_RESET = 8'h13;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // control fields
  localparam int CTRL_MODE_LSB = 0; // [1:0] wire count
  localparam int CTRL_PRIO_BIT = 2;
  localparam int CTRL_DIR_BIT = 3;
  localparam int CTRL_OVL_BIT = 4;

  // command fields, write-only pulses
  localparam int CMD_START_BIT = 0;
  localparam int CMD_END_BIT = 1;

  // status fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_REQ_BIT = 1;
  localparam int STAT_REFUSED_BIT = 2;
  localparam int STAT_GRANT_BIT = 3;
  localparam int STAT_DIRPH_BIT = 4;

  // --------------------------------------------------------------------
  // timing
  // --------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int US_NS = 1000;
  localparam int CYC_PER_US = US_NS / CLK_PERIOD_NS;
  localparam logic [7:0] PRE_LAST = 8'(CYC_PER_US - 1);
  localparam logic [8:0] US_MAX = 9'h1FF;

  // --------------------------------------------------------------------
  // types
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_TWO = 2'h0,
    MODE_THREE = 2'h1,
    MODE_FOUR = 2'h2,
    MODE_FOUR_ALT = 2'h3
  } wca_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_WAIT = 3'h2,
    ST_GRANT = 3'h4
  } wca_state_t;

endpackage

// [rtl/wca_link_if.sv]
`timescale 1ns/100ps
interface wca_link_if;
  import wca_pkg::*;

  // timer control and events
  logic tmr_start;
  logic tmr_stop;
  logic [7:0] t1_val;
  logic [7:0] t2_val;
  logic t1_hit;
  logic t2_hit;

  // pin drive inputs
  wca_mode_t mode;
  logic req;
  logic prio;
  logic txn_prio;
  logic dir_phase;
  logic dir_tx;
  logic overlap;

  modport core (
    output tmr_start, tmr_stop, t1_val, t2_val,
    output mode, req, prio, txn_prio, dir_phase, dir_tx, overlap,
    input t1_hit, t2_hit
  );
  modport tmr (
    input tmr_start, tmr_stop, t1_val, t2_val,
    output t1_hit, t2_hit
  );
  modport pins (
    input mode, req, prio, txn_prio, dir_phase, dir_tx, overlap
  );
endinterface

// [rtl/wca_us_timer.sv]
`timescale 1ns/100ps
module wca_us_timer import wca_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // core link
  wca_link_if.tmr lk
);

  typedef struct packed {
    logic run;
    logic [7:0] pre;
    logic [8:0] us;
    logic t1_hit;
    logic t2_hit;
  } wca_tmr_t;

  wca_tmr_t s;
  wca_tmr_t next_s;
  logic tick;

  // --------------------------------------------------------------------
  // microsecond base restarted by each request rising edge
  // --------------------------------------------------------------------
  always_comb begin
    next_s = s;
    tick = s.run && (s.pre == PRE_LAST);
    next_s.t1_hit = 1'b0;
    next_s.t2_hit = 1'b0;
    if (lk.tmr_start) begin
      next_s.run = 1'b1; // R17
      next_s.pre = 8'h00;
      next_s.us = 9'h000;
    end else if (lk.tmr_stop) begin
      next_s.run = 1'b0;
    end else if (s.run) begin
      next_s.pre = tick ? 8'h00 : s.pre + 8'h01;
      if (tick) begin
        // us becomes value+1 on this tick
        next_s.t1_hit = (s.us == {1'b0, lk.t1_val}); // R15 R17
        next_s.t2_hit = (s.us == {1'b0, lk.t2_val}); // R16 R17
        if (s.us == US_MAX) begin
          next_s.run = 1'b0;
        end else begin
          next_s.us = s.us + 9'h001;
        end
      end
    end
  end

  // state register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign lk.t1_hit = s.t1_hit;
  assign lk.t2_hit = s.t2_hit;

endmodule

// [rtl/wca_pin_drive.sv]
`timescale 1ns/100ps
module wca_pin_drive import wca_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // core link
  wca_link_if.pins lk,
  // pins
  output logic activity_req,
  output logic status_out,
  output logic channel_overlap_flag
);

  typedef struct packed {
    logic act;
    logic sta;
    logic ovl;
  } wca_pin_t;

  wca_pin_t s;
  wca_pin_t next_s;

  // --------------------------------------------------------------------
  // registered pin levels per wire mode
  // --------------------------------------------------------------------
  always_comb begin
    next_s = '0;
    if (lk.mode == MODE_TWO) begin
      next_s.act = lk.prio; // R1 R2 R5
    end else begin
      next_s.act = lk.req; // R2 R7
      if (lk.req) begin
        // priority first, direction once t2 has passed
        next_s.sta = lk.dir_phase ? lk.dir_tx : lk.txn_prio; // R9 R10 R11
      end
      next_s.ovl = lk.mode[1] && lk.req && lk.overlap; // R12
    end
  end

  // state register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign activity_req = s.act;
  assign status_out = s.sta;
  assign channel_overlap_flag = s.ovl;

endmodule

// [rtl/wca_top.sv]
// Design decision made here: the plain strobed port.
`timescale 1ns/100ps
//
// Function
// R1: supports two-, three- and four-wire coexistence signalling, chosen by mode.
// R2: request, status and refusal sit on three fixed lines; two-wire uses first.
// R3: peer holds busy while moving its own packets.
// R4: low-priority sends are withheld while peer busy; software sees busy.
// R5: priority output high in high-priority activity; peer then defers.
// R6: busy input is only readable by software, no hardware reaction.
// R7: request stays high for the whole transaction.
// R8: request rises t1 before the radio settle step; settle go at t1.
// R9: status shows priority when request rises.
// R10: after t2 status shows direction, high transmit, low receive.
// R11: direction updates ahead of each transmit or receive.
// R12: optional overlap output under software control.
// R13: peer drives refusal stable within t1 after request.
// R14: refusal high at sample time means transaction is not started.
// R15: 8-bit t1 minus one setting, reset 0x31, refusal sampled at t1.
// R16: 8-bit t2 minus one setting, reset 0x13, sets direction switch.
// R17: microsecond counter restarts on request rise, compares value plus one.
module wca_top import wca_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // peer inputs
  input wire logic peer_radio_busy,
  input wire logic peer_refusal,
  // peer outputs
  output logic activity_req,
  output logic status_out,
  output logic channel_overlap_flag,
  // radio sequencer
  output logic settle_go
);

  // --------------------------------------------------------------------
  // registered state
  // --------------------------------------------------------------------
  typedef struct packed {
    // sequencing
    wca_state_t st;
    // software settings
    logic [7:0] t1;
    logic [7:0] t2;
    logic [1:0] mode;
    logic prio;
    logic dir_tx;
    logic overlap;
    // transaction progress
    logic txn_prio;
    logic req;
    logic dir_phase;
    logic refused;
    logic granted;
    // registered outputs
    logic settle_go;
    logic [7:0] rdata;
  } wca_core_t;

  // registered state and its next value
  wca_core_t s;
  wca_core_t next_s;

  // command pulses decoded from a write
  logic start_cmd;
  logic end_cmd;

  // timer restart and stop strobes
  logic start_fire;
  logic stop_fire;

  wca_link_if lk ();

  // --------------------------------------------------------------------
  // reset image, a constant so the reset branch loads no logic
  // --------------------------------------------------------------------
  localparam wca_core_t RESET_S = '{
    st: ST_IDLE,
    t1: T1_RESET, // R15
    t2: T2_RESET, // R16
    mode: CTRL_RESET[CTRL_MODE_LSB +: 2],
    prio: CTRL_RESET[CTRL_PRIO_BIT],
    dir_tx: CTRL_RESET[CTRL_DIR_BIT],
    overlap: CTRL_RESET[CTRL_OVL_BIT],
    txn_prio: 1'b0,
    req: 1'b0,
    dir_phase: 1'b0,
    refused: 1'b0,
    granted: 1'b0,
    settle_go: 1'b0,
    rdata: 8'h00
  };

  // --------------------------------------------------------------------
  // register access and transaction sequencing
  // --------------------------------------------------------------------
  always_comb begin
    next_s = s;
    // pulses and read data are zero unless set below
    next_s.settle_go = 1'b0;
    next_s.rdata = 8'h00;
    start_cmd = 1'b0;
    end_cmd = 1'b0;
    start_fire = 1'b0;
    stop_fire = 1'b0;

    // ------------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------------
    if (reg_wr) begin
      case (reg_addr)
        ADDR_T1: begin
          next_s.t1 = reg_wdata; // R15
        end
        ADDR_T2: begin
          next_s.t2 = reg_wdata; // R16
        end
        ADDR_CTRL: begin
          // mode, priority, direction and overlap in one write
          next_s.mode = reg_wdata[CTRL_MODE_LSB +: 2]; // R1
          next_s.prio = reg_wdata[CTRL_PRIO_BIT];
          next_s.dir_tx = reg_wdata[CTRL_DIR_BIT]; // R11
          next_s.overlap = reg_wdata[CTRL_OVL_BIT]; // R12
        end
        ADDR_CMD: begin
          start_cmd = reg_wdata[CMD_START_BIT];
          end_cmd = reg_wdata[CMD_END_BIT];
        end
        ADDR_STAT: begin
          // status is read-only, the write is dropped
        end
        default: begin
        end
      endcase
    end

    // ------------------------------------------------------------------
    // register reads, data one cycle later
    // ------------------------------------------------------------------
    if (reg_rd) begin
      case (reg_addr)
        ADDR_T1: begin
          next_s.rdata = s.t1;
        end
        ADDR_T2: begin
          next_s.rdata = s.t2;
        end
        ADDR_CTRL: begin
          next_s.rdata[CTRL_MODE_LSB +: 2] = s.mode;
          next_s.rdata[CTRL_PRIO_BIT] = s.prio;
          next_s.rdata[CTRL_DIR_BIT] = s.dir_tx;
          next_s.rdata[CTRL_OVL_BIT] = s.overlap;
        end
        ADDR_STAT: begin
          next_s.rdata[STAT_BUSY_BIT] = peer_radio_busy; // R4 R6
          next_s.rdata[STAT_REQ_BIT] = s.req;
          next_s.rdata[STAT_REFUSED_BIT] = s.refused;
          next_s.rdata[STAT_GRANT_BIT] = s.granted;
          next_s.rdata[STAT_DIRPH_BIT] = s.dir_phase;
        end
        ADDR_CMD: begin
          next_s.rdata = 8'h00; // command pulses leave nothing to read
        end
        default: begin
          // unmapped places read as zero
          next_s.rdata = 8'h00;
        end
      endcase
    end

    // ------------------------------------------------------------------
    // transaction state machine, three- and four-wire only
    // ------------------------------------------------------------------
    case (s.st)
      ST_IDLE: begin
        // starts are taken in three- and four-wire modes only
        if (start_cmd && (s.mode != MODE_TWO)) begin
          next_s.st = ST_WAIT;
          next_s.req = 1'b1; // R7 R8
          next_s.txn_prio = s.prio; // R9
          next_s.dir_phase = 1'b0;
          next_s.refused = 1'b0;
          next_s.granted = 1'b0;
          start_fire = 1'b1; // R17
        end
      end
      ST_WAIT: begin
        if (end_cmd) begin
          next_s.st = ST_IDLE;
          next_s.req = 1'b0;
          stop_fire = 1'b1;
        end else if (lk.t1_hit) begin
          // the refusal line is looked at on the t1 cycle only
          if (peer_refusal) begin
            // refused: drop the request, never start
            next_s.st = ST_IDLE; // R13 R14
            next_s.req = 1'b0;
            next_s.refused = 1'b1;
            stop_fire = 1'b1;
          end else begin
            next_s.st = ST_GRANT;
            next_s.granted = 1'b1;
            next_s.settle_go = 1'b1; // R8
          end
        end
      end
      ST_GRANT: begin
        // granted until software ends the transaction
        if (end_cmd) begin
          next_s.st = ST_IDLE; // R7
          next_s.req = 1'b0;
          stop_fire = 1'b1;
        end
      end
      default: begin
        // an illegal state code falls back to idle
        next_s.st = ST_IDLE;
        next_s.req = 1'b0;
      end
    endcase

    // ------------------------------------------------------------------
    // a switch to two-wire drops an open transaction, since the
    // request pin then carries the priority level instead
    // ------------------------------------------------------------------
    if ((next_s.mode == MODE_TWO) && (next_s.st != ST_IDLE)) begin
      next_s.st = ST_IDLE; // R1
      next_s.req = 1'b0;
      next_s.settle_go = 1'b0;
      stop_fire = 1'b1;
    end

    // ------------------------------------------------------------------
    // status changes from priority to direction at t2
    // ------------------------------------------------------------------
    if (next_s.req && lk.t2_hit) begin
      next_s.dir_phase = 1'b1; // R10
    end
    // the direction phase ends with the request
    if (!next_s.req) begin
      next_s.dir_phase = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= RESET_S;
    end else begin
      s <= next_s;
    end
  end

  // --------------------------------------------------------------------
  // link to the helpers
  // --------------------------------------------------------------------
  // timer controls
  assign lk.tmr_start = start_fire;
  assign lk.tmr_stop = stop_fire;
  assign lk.t1_val = s.t1;
  assign lk.t2_val = s.t2;

  // pin drive inputs, all registered
  assign lk.mode = wca_mode_t'(s.mode);
  assign lk.req = s.req;
  assign lk.prio = s.prio; // R5
  assign lk.txn_prio = s.txn_prio;
  assign lk.dir_phase = s.dir_phase;
  assign lk.dir_tx = s.dir_tx;
  assign lk.overlap = s.overlap;

  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  // microsecond timer
  wca_us_timer u_timer (
    .clk(clk),
    .arst_n(arst_n),
    .lk(lk.tmr)
  );

  // registered pin drivers
  wca_pin_drive u_pins (
    .clk(clk),
    .arst_n(arst_n),
    .lk(lk.pins),
    .activity_req(activity_req),
    .status_out(status_out),
    .channel_overlap_flag(channel_overlap_flag)
  );

  // --------------------------------------------------------------------
  // outputs straight from flip-flops
  // --------------------------------------------------------------------
  assign reg_rdata = s.rdata;
  assign settle_go = s.settle_go;

endmodule

// [tb/wca_checker_assertions.sv]
`timescale 1ns/100ps
module wca_checker import wca_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // peer pins and radio settle strobe
  input wire logic peer_radio_busy,
  input wire logic peer_refusal,
  input wire logic activity_req,
  input wire logic status_out,
  input wire logic channel_overlap_flag,
  input wire logic settle_go
);
  localparam int CY = CYC_PER_US;
  logic [7:0] t1s;
  logic [7:0] t2s;
  logic [7:0] cts;
  logic req_d;
  int age;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // shadow settings and cycles since the request pin rose
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      t1s <= T1_RESET;
      t2s <= T2_RESET;
      cts <= CTRL_RESET;
      req_d <= 1'b0;
      age <= 0;
    end else begin
      req_d <= activity_req;
      age <= (activity_req && !req_d) ? 0 : age + 1;
      if (reg_wr && reg_addr == ADDR_T1)
        t1s <= reg_wdata;
      if (reg_wr && reg_addr == ADDR_T2)
        t2s <= reg_wdata;
      if (reg_wr && reg_addr == ADDR_CTRL)
        cts <= reg_wdata;
    end
  end
  a_rdata_slot: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("stray read data");
  a_settle_time: assert property (
    settle_go |-> age == CY * (t1s + 1) - 1) else $error("settle time off");
  a_settle_pulse: assert property (
    settle_go |=> !settle_go) else $error("settle not a pulse");
  a_refusal_blocks: assert property (
    settle_go |-> !$past(peer_refusal)) else $error("refused but started");
  a_req_held: assert property (
    $rose(activity_req) && cts[1:0] != 2'h0 |-> activity_req[*8])
    else $error("request dropped early");
  a_prio_phase: assert property (
    activity_req && $past(activity_req) && age < CY * (t2s + 1)
    |-> $stable(status_out)) else $error("status moved early");
  a_dir_shown: assert property (
    activity_req && cts[1:0] != 2'h0 && age == CY * (t2s + 1)
    |-> status_out == cts[CTRL_DIR_BIT]) else $error("direction wrong");
  a_overlap_gate: assert property (
    channel_overlap_flag |-> activity_req && cts[1])
    else $error("overlap without request");
  a_two_wire_prio: assert property (
    cts[1:0] == 2'h0 && $past(cts, 2) == cts
    |-> activity_req == cts[CTRL_PRIO_BIT]) else $error("priority wrong");
endmodule
bind wca_top wca_checker wca_checker_inst (.clk, .arst_n, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .peer_radio_busy,
  .peer_refusal, .activity_req, .status_out, .channel_overlap_flag,
  .settle_go);

// [tb/wca_peer_model.sv]
`timescale 1ns/100ps
module wca_peer_model (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // device pin
  input wire logic activity_req,
  // bench commands
  input wire logic busy_cmd,
  input wire logic deny_cmd,
  input wire logic [7:0] answer_lat,
  // peer pins
  output logic peer_radio_busy,
  output logic peer_refusal
);
  logic [7:0] age;
  // verdict held from answer time on, toggling noise otherwise
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      age <= 8'h00;
      peer_refusal <= 1'b0;
    end else begin
      age <= !activity_req ? 8'h00 : age + {7'h00, age != 8'hFF};
      if (activity_req && age >= answer_lat)
        peer_refusal <= deny_cmd;
      else
        peer_refusal <= ~peer_refusal;
    end
  end
  // own traffic marks busy, deferred while the device holds activity_req high, in any wire mode
  assign peer_radio_busy = busy_cmd & ~activity_req;
endmodule

// [tb/wca_top_bench.sv]
`timescale 1ns/100ps
module wca_top_bench import wca_pkg::*;;
  logic clk = 0;
  logic arst_n = 0;
  logic reg_wr = 0;
  logic reg_rd = 0;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [7:0] lat = 8'h01;
  logic busy = 0;
  logic deny = 0;
  logic busy_w, deny_w, act, stat, ovl, go;
  int cyc = 0;
  int mismatches = 0;
  int checks = 0;
  wca_top wca_top_inst (.clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .peer_radio_busy(busy_w), .peer_refusal(deny_w),
    .activity_req(act), .status_out(stat), .channel_overlap_flag(ovl),
    .settle_go(go));
  wca_peer_model wca_peer_model_inst (.clk, .arst_n, .activity_req(act),
    .busy_cmd(busy), .deny_cmd(deny), .answer_lat(lat),
    .peer_radio_busy(busy_w), .peer_refusal(deny_w));
  // clock
  initial forever #2.5 clk = ~clk;
  // cycle count and hang limit
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      end_sim;
    end
  end
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic at(int n);
    while (cyc < n) begin
      @(posedge clk);
      #1;
    end
  endtask
  task automatic wr(logic [11:0] a, logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [11:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask
  // reset values, read-write, unmapped place
  task automatic t_regs;
    logic [7:0] v;
    rd(ADDR_T1, v);
    chk(v, 8'h31);
    rd(ADDR_T2, v);
    chk(v, 8'h13);
    wr(12'hF17, 8'hFF);
    rd(12'hF17, v);
    chk(v, 8'h00);
    wr(ADDR_T1, 8'hA5);
    wr(ADDR_T2, 8'h5A);
    rd(ADDR_T1, v);
    chk(v, 8'hA5);
    rd(ADDR_T2, v);
    chk(v, 8'h5A);
    wr(ADDR_T1, 8'h01);
    wr(ADDR_T2, 8'h00);
    $display("test regs done");
  endtask
  // two-wire priority and busy visibility
  task automatic t_two;
    logic [7:0] v;
    busy <= 1'b1;
    rd(ADDR_STAT, v);
    chk(v & 8'h03, 8'h01);
    wr(ADDR_CTRL, 8'h04);
    at(cyc + 1);
    chk(act, 1);
    chk(stat, 0);
    wr(ADDR_CMD, 8'h01);
    wr(ADDR_CTRL, 8'h00);
    at(cyc + 2);
    chk(act, 0);
    rd(ADDR_STAT, v);
    chk(v & 8'h03, 8'h01);
    busy <= 1'b0;
    $display("test two-wire done");
  endtask
  // one transaction: priority, direction, verdict, end
  task automatic t_txn(logic [1:0] m, logic p, logic d, logic o,
                       logic dn, logic [7:0] l);
    logic [7:0] v;
    int c2;
    deny <= dn;
    lat <= l;
    wr(ADDR_CTRL, {3'h0, o, d, p, m});
    wr(ADDR_CMD, 8'h01);
    at(cyc + 1);
    c2 = cyc;
    chk(act, 1);
    chk(stat, p);
    chk(ovl, m[1] & o);
    at(c2 + 201);
    chk(stat, d);
    wr(ADDR_CTRL, {3'h0, o, ~d, p, m});
    at(cyc + 2);
    chk(stat, !d);
    at(c2 + 399);
    chk(go, 0);
    at(c2 + 400);
    chk(go, !dn);
    at(c2 + 401);
    chk(act, !dn);
    rd(ADDR_STAT, v);
    chk(v & 8'h0E, {4'h0, ~dn, dn, ~dn, 1'b0});
    if (!dn) begin
      wr(ADDR_CMD, 8'h02);
      chk(act, 1);
      at(cyc + 1);
      chk(act, 0);
    end
    $display("test transaction mode %0d done", m);
  endtask
  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    t_regs;
    t_two;
    t_txn(2'h1, 1, 1, 1, 0, 8'h01);
    t_txn(2'h2, 0, 0, 1, 1, 8'hFA);
    t_txn(2'h3, 1, 0, 1, 0, 8'hFA);
    t_txn(2'h1, 0, 1, 0, 1, 8'h01);
    end_sim;
  end
endmodule
